/* File: common/fcs_consts.vh */
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
// ==========================================================
// register indices on the plain register port
`define FCS_REG_DIV       4'h0
`define FCS_REG_OPT       4'h1
`define FCS_REG_STAT      4'h2
`define FCS_REG_CMD       4'h3
`define FCS_REG_ADDR      4'h4
`define FCS_REG_DATA      4'h5
`define FCS_REG_MODE      4'h6
`define FCS_REG_MARGIN    4'h7
// ==========================================================
// divider register fields
`define FCS_DIV_LOADED    7
`define FCS_DIV_PRE8      6
// ==========================================================
// status register fields
`define FCS_ST_CBE        7
`define FCS_ST_CC         6
`define FCS_ST_PROTECTION_VIOLATION_FLAG      5
`define FCS_ST_ACCESS_ERROR_FLAG     4
`define FCS_ST_BLANK      2
`define FCS_ST_FAIL       1
`define FCS_STAT_RESET    8'hC0
// ==========================================================
// command codes
`define FCS_CMD_ERSVFY    7'h05
`define FCS_CMD_PROG      7'h20
`define FCS_CMD_BURST     7'h25
`define FCS_CMD_SECERS    7'h40
`define FCS_CMD_MASERS    7'h41
`define FCS_CMD_MARGIN    7'h75
// ==========================================================
// option byte source and timing
`define FCS_OPT_ADDR      16'h7F0E
`define FCS_OPT_FAULT     8'hFF
`define FCS_EV_EXTRA      4'h4
`define FCS_PROG_TICKS    8'h08
`define FCS_ERASE_TICKS   8'h40
`endif

/* File: rtl/fcs_clkdiv.v */
`timescale 1ns/100ps
`include "fcs_consts.vh"
// timing clock divider: one tick per divided period
module fcs_clkdiv
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // setting
  input  wire       enable,
  input  wire       prescale_by_eight,
  input  wire [5:0] divider_value,
  // output
  output reg        tick
);
  reg [2:0] pre_reg;
  reg [5:0] cnt_reg;
  wire      pre_done;
  assign pre_done = !prescale_by_eight || (pre_reg == 3'h7);
  // ========================================================
  // divide by (value+1), optionally by eight first
  always @(posedge sys_clk)
  begin
    if (!rst_n || !enable)
    begin
      pre_reg <= 3'h0;
      cnt_reg <= 6'h00;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= 1'b0;
      pre_reg <= pre_reg + 3'h1;
      if (pre_done)
      begin
        pre_reg <= 3'h0;
        if (cnt_reg == divider_value)
        begin
          cnt_reg <= 6'h00;
          tick    <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end
endmodule

/* File: rtl/fcs_optload.v */
`timescale 1ns/100ps
`include "fcs_consts.vh"
// fetches the option byte from the array after reset
module fcs_optload
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // array read port
  output reg         rd_req,
  output wire [15:0] rd_addr,
  input  wire        rd_valid,
  input  wire [7:0]  rd_data,
  input  wire        rd_dbl_fault,
  // result
  output reg  [7:0]  opt_byte,
  output reg         done
);
  assign rd_addr = `FCS_OPT_ADDR; // RULE2
  // ========================================================
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_req   <= 1'b0;
      opt_byte <= 8'h00;
      done     <= 1'b0;
    end
    else if (!done)
    begin
      rd_req <= 1'b1;
      if (rd_req && rd_valid)
      begin
        rd_req   <= 1'b0;
        done     <= 1'b1;
        // a faulty phrase must not leave half-trusted bits
        opt_byte <= rd_dbl_fault ? `FCS_OPT_FAULT : rd_data; // RULE3 RULE2
      end
    end
  end
endmodule

/* File: rtl/fcs_sequencer.v */
`timescale 1ns/100ps
`include "fcs_consts.vh"
// Notes on behaviour
// RULE1: option byte readable, writes ignored
// RULE2: reset loads option byte from 0x7F0E
// RULE3: double-bit fault sets all option bits
// RULE4: software sets divider for 150-200 kHz
// RULE5: divider write sets divider-loaded bit
// RULE6: unloaded divider: command aborted, access error
// RULE7: software starts with flags clear, buffer empty
// RULE8: three steps in order, no interleaved writes
// RULE9: address write, command write, launch write
// RULE10: completion sets command complete flag
// RULE11: complete only after all burst commands
// RULE12: decode erase verify, program, burst
// RULE13: decode sector, mass, margin (special only)
// RULE14: mass erase only without protection
// RULE15: software programs erased locations only
// RULE16: erase verify ignores address and data
// RULE17: erase verify takes array size plus few
// RULE18: all erased sets blank flag
// RULE19: non-erased stops; fail set in special
// RULE20: program writes opening data to address
// RULE21: protected program: violation, no launch
// RULE22: invalid code in normal mode: access error
// RULE23: fail cleared only by writing one
// RULE24: launch clears buffer flag; sets when free
// RULE25: no loaded divider: divider idle, no launch
module fcs_sequencer
#(
  parameter AW        = 14,
  parameter ARRAY_CNT = 16384
)
(
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst_n,
  // register port
  input  wire [3:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [7:0]    reg_rdata,
  // array write from processor
  input  wire          arr_wr,
  input  wire [AW-1:0] arr_waddr,
  input  wire [15:0]   arr_wdata,
  // protection inputs
  input  wire          prot_hit,
  input  wire          prot_any,
  // array operation port
  output reg           op_prog,
  output reg           op_erase,
  output reg           op_mass,
  output reg  [AW-1:0] op_addr,
  output reg  [15:0]   op_data,
  output reg           op_rd,
  input  wire          arr_erased,
  // option byte fetch
  output reg           opt_rd_req,
  output reg  [15:0]   opt_rd_addr,
  input  wire          opt_rd_valid,
  input  wire [7:0]    opt_rd_data,
  input  wire          opt_dbl_fault,
  // status out
  output reg           cmd_done
);
  localparam S_IDLE  = 5'b00001;
  localparam S_VFY   = 5'b00010;
  localparam S_TAIL  = 5'b00100;
  localparam S_TIMED = 5'b01000;
  localparam S_NEXT  = 5'b10000;
  localparam [1:0] SQ_NONE = 2'h0;
  localparam [1:0] SQ_ADDR = 2'h1;
  localparam [1:0] SQ_CMD  = 2'h2;

  // ========================================================
  // registers
  reg  [7:0]    div_reg;
  reg  [7:0]    stat_reg;
  reg  [6:0]    cmd_reg;
  reg  [AW-1:0] addr_reg;
  reg  [15:0]   data_reg;
  reg           special_reg;
  reg  [15:0]   margin_reg;
  reg  [1:0]    sq_reg;
  reg  [4:0]    state_reg;
  reg  [AW:0]   cnt_reg;
  reg  [7:0]    ticks_reg;
  reg           pend_reg;
  reg  [AW-1:0] pend_addr_reg;
  reg  [15:0]   pend_data_reg;
  reg           burst_reg;
  reg  [6:0]    run_cmd_reg;
  wire          tick;
  wire          ld_rd_req;
  wire [15:0]   ld_rd_addr;
  wire [7:0]    opt_byte;
  wire          opt_done;
  wire          loaded;
  wire          valid_cmd;
  wire          launch;
  wire          busy;
  wire          fail_w1c;
  wire [AW+7:0] addr_wide;

  assign loaded   = div_reg[`FCS_DIV_LOADED];
  assign busy     = (state_reg != S_IDLE);
  assign addr_wide = {8'h00, addr_reg};
  assign fail_w1c = reg_wr && (reg_addr == `FCS_REG_STAT) &&
                    reg_wdata[`FCS_ST_FAIL];
  assign valid_cmd = (reg_wdata[6:0] == `FCS_CMD_ERSVFY) ||
                     (reg_wdata[6:0] == `FCS_CMD_PROG)   ||
                     (reg_wdata[6:0] == `FCS_CMD_BURST)  ||
                     (reg_wdata[6:0] == `FCS_CMD_SECERS) ||
                     (reg_wdata[6:0] == `FCS_CMD_MASERS) ||
                     (special_reg &&
                      reg_wdata[6:0] == `FCS_CMD_MARGIN); // RULE12 RULE13
  assign launch = reg_wr && (reg_addr == `FCS_REG_STAT) &&
                  reg_wdata[`FCS_ST_CBE] && (sq_reg == SQ_CMD) &&
                  stat_reg[`FCS_ST_CBE];

  // ========================================================
  // sub blocks
  fcs_clkdiv u_div
  (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .enable            (loaded), // RULE25
    .prescale_by_eight (div_reg[`FCS_DIV_PRE8]),
    .divider_value     (div_reg[5:0]),
    .tick              (tick)
  );

  fcs_optload u_opt
  (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .rd_req       (ld_rd_req),
    .rd_addr      (ld_rd_addr),
    .rd_valid     (opt_rd_valid),
    .rd_data      (opt_rd_data),
    .rd_dbl_fault (opt_dbl_fault),
    .opt_byte     (opt_byte),
    .done         (opt_done)
  );

  // ========================================================
  // option fetch outputs registered
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      opt_rd_req  <= 1'b0;
      opt_rd_addr <= 16'h0000;
    end
    else
    begin
      opt_rd_req  <= ld_rd_req && !opt_done;
      opt_rd_addr <= ld_rd_addr;
    end
  end

  // ========================================================
  // register writes and command write sequence
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_reg     <= 8'h00;
      special_reg <= 1'b0;
      cmd_reg     <= 7'h00;
      addr_reg    <= {AW{1'b0}};
      data_reg    <= 16'h0000;
      sq_reg      <= SQ_NONE;
    end
    else
    begin
      if (reg_wr && reg_addr == `FCS_REG_DIV)
        div_reg <= {1'b1, reg_wdata[6:0]}; // RULE5
      if (reg_wr && reg_addr == `FCS_REG_MODE)
        special_reg <= reg_wdata[0];
      // array write opens a sequence; a second one aborts
      if (arr_wr && stat_reg[`FCS_ST_CBE])
      begin
        addr_reg <= arr_waddr;
        data_reg <= arr_wdata;
        sq_reg   <= (sq_reg == SQ_NONE) ? SQ_ADDR : SQ_NONE;
      end
      else if (reg_wr && reg_addr == `FCS_REG_CMD)
      begin
        cmd_reg <= reg_wdata[6:0];
        sq_reg  <= (sq_reg == SQ_ADDR && valid_cmd && loaded)
                   ? SQ_CMD : SQ_NONE; // RULE6 RULE22
      end
      else if (launch)
        sq_reg <= SQ_NONE;
      else if (reg_wr && reg_addr == `FCS_REG_STAT &&
               sq_reg != SQ_NONE)
        sq_reg <= SQ_NONE;
    end
  end

  // ========================================================
  // engine and status
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stat_reg      <= `FCS_STAT_RESET;
      state_reg     <= S_IDLE;
      cnt_reg       <= {(AW+1){1'b0}};
      ticks_reg     <= 8'h00;
      pend_reg      <= 1'b0;
      pend_addr_reg <= {AW{1'b0}};
      pend_data_reg <= 16'h0000;
      burst_reg     <= 1'b0;
      run_cmd_reg   <= 7'h00;
      margin_reg    <= 16'h0000;
      op_prog       <= 1'b0;
      op_erase      <= 1'b0;
      op_mass       <= 1'b0;
      op_addr       <= {AW{1'b0}};
      op_data       <= 16'h0000;
      op_rd         <= 1'b0;
      cmd_done      <= 1'b0;
    end
    else
    begin
      op_prog  <= 1'b0;
      op_erase <= 1'b0;
      op_mass  <= 1'b0;
      op_rd    <= 1'b0;
      cmd_done <= 1'b0;
      // software clears of the error flags, and of the blank flag in special mode
      if (reg_wr && reg_addr == `FCS_REG_STAT)
      begin
        if (reg_wdata[`FCS_ST_ACCESS_ERROR_FLAG])
          stat_reg[`FCS_ST_ACCESS_ERROR_FLAG] <= 1'b0;
        if (reg_wdata[`FCS_ST_PROTECTION_VIOLATION_FLAG])
          stat_reg[`FCS_ST_PROTECTION_VIOLATION_FLAG] <= 1'b0;
        if (special_reg && reg_wdata[`FCS_ST_BLANK])
          stat_reg[`FCS_ST_BLANK] <= 1'b0;
        if (fail_w1c)
          stat_reg[`FCS_ST_FAIL] <= 1'b0; // RULE23
        if (sq_reg != SQ_NONE && !launch)
          stat_reg[`FCS_ST_ACCESS_ERROR_FLAG] <= 1'b1;
      end
      if (arr_wr && sq_reg != SQ_NONE)
        stat_reg[`FCS_ST_ACCESS_ERROR_FLAG] <= 1'b1;
      if (reg_wr && reg_addr == `FCS_REG_CMD &&
          (sq_reg != SQ_ADDR || !valid_cmd || !loaded))
        stat_reg[`FCS_ST_ACCESS_ERROR_FLAG] <= 1'b1; // RULE6 RULE22
      // launch: protection checked before anything starts
      if (launch)
      begin
        if ((cmd_reg == `FCS_CMD_PROG || cmd_reg == `FCS_CMD_BURST ||
             cmd_reg == `FCS_CMD_SECERS) && prot_hit)
          stat_reg[`FCS_ST_PROTECTION_VIOLATION_FLAG] <= 1'b1; // RULE21
        else if (cmd_reg == `FCS_CMD_MASERS && prot_any)
          stat_reg[`FCS_ST_PROTECTION_VIOLATION_FLAG] <= 1'b1; // RULE14
        else if (busy && !(burst_reg && cmd_reg == `FCS_CMD_BURST))
          stat_reg[`FCS_ST_ACCESS_ERROR_FLAG] <= 1'b1;
        else if (busy)
        begin
          // second burst waits in the buffer stage
          pend_reg      <= 1'b1;
          pend_data_reg <= data_reg;
          stat_reg[`FCS_ST_CBE] <= 1'b0; // RULE24
        end
        else
        begin
          stat_reg[`FCS_ST_CBE]   <= 1'b0; // RULE24
          stat_reg[`FCS_ST_CC]    <= 1'b0;
          stat_reg[`FCS_ST_BLANK] <= 1'b0;
          run_cmd_reg <= cmd_reg;
          burst_reg   <= (cmd_reg == `FCS_CMD_BURST);
          op_addr     <= addr_reg; // RULE20
          op_data     <= data_reg; // RULE20
          ticks_reg   <= 8'h00;
          cnt_reg     <= {(AW+1){1'b0}};
          if (cmd_reg == `FCS_CMD_ERSVFY)
            state_reg <= S_VFY; // RULE16
          else if (cmd_reg == `FCS_CMD_MARGIN)
          begin
            margin_reg <= data_reg;
            state_reg  <= S_TAIL;
          end
          else
            state_reg <= S_TIMED;
        end
      end
      case (state_reg)
        S_IDLE:
          ;
        S_VFY:
        begin
          // one array address per bus cycle
          op_rd   <= 1'b1;
          op_addr <= cnt_reg[AW-1:0];
          if (op_rd && !arr_erased)
          begin
            if (special_reg)
              stat_reg[`FCS_ST_FAIL] <= 1'b1; // RULE19
            cnt_reg   <= {(AW+1){1'b0}};
            state_reg <= S_TAIL;
          end
          else if (cnt_reg == ARRAY_CNT[AW:0])
          begin
            op_rd     <= 1'b0;
            stat_reg[`FCS_ST_BLANK] <= 1'b1; // RULE18
            cnt_reg   <= {(AW+1){1'b0}};
            state_reg <= S_TAIL; // RULE17
          end
          else
            cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1}; // RULE17
        end
        S_TIMED:
        begin
          if (tick)
            ticks_reg <= ticks_reg + 8'h01;
          op_prog  <= (run_cmd_reg == `FCS_CMD_PROG) ||
                      (run_cmd_reg == `FCS_CMD_BURST);
          op_erase <= (run_cmd_reg == `FCS_CMD_SECERS);
          op_mass  <= (run_cmd_reg == `FCS_CMD_MASERS);
          // erase runs longer on the divided time base
          if (ticks_reg == (op_prog ? `FCS_PROG_TICKS
                                    : `FCS_ERASE_TICKS))
          begin
            stat_reg[`FCS_ST_CBE] <= 1'b1; // RULE24
            state_reg <= burst_reg ? S_NEXT : S_TAIL;
          end
        end
        S_NEXT:
        begin
          if (pend_reg)
          begin
            pend_reg  <= 1'b0;
            op_addr   <= op_addr + {{(AW-1){1'b0}}, 1'b1}; // RULE12
            op_data   <= pend_data_reg;
            ticks_reg <= 8'h00;
            cnt_reg   <= {(AW+1){1'b0}};
            stat_reg[`FCS_ST_CBE] <= 1'b1;
            state_reg <= S_TIMED;
          end
          else
            state_reg <= S_TAIL; // RULE11
        end
        S_TAIL:
        begin
          cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
          // a burst buffered during the tail must run first
          if (pend_reg)
            state_reg <= S_NEXT; // RULE11
          else if (cnt_reg[3:0] >= `FCS_EV_EXTRA && !launch)
          begin
            stat_reg[`FCS_ST_CC]  <= 1'b1; // RULE10
            stat_reg[`FCS_ST_CBE] <= 1'b1; // RULE24
            cmd_done  <= 1'b1;
            burst_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ========================================================
  // read data, one cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        `FCS_REG_DIV:    reg_rdata <= div_reg;
        `FCS_REG_OPT:    reg_rdata <= opt_byte; // RULE1
        `FCS_REG_STAT:   reg_rdata <= stat_reg;
        `FCS_REG_CMD:    reg_rdata <= {1'b0, cmd_reg};
        `FCS_REG_ADDR:   reg_rdata <= special_reg ? addr_wide[7:0] : 8'h00;
        `FCS_REG_DATA:   reg_rdata <= special_reg ? data_reg[7:0] : 8'h00;
        `FCS_REG_MODE:   reg_rdata <= {7'h00, special_reg};
        `FCS_REG_MARGIN: reg_rdata <= margin_reg[7:0];
        default:         reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end
endmodule

/* File: testbench/fcs_array_model.sv */
`timescale 1ns/100ps
// ==========
// flash array answering the fetch and verify reads
module fcs_array_model
#(
  parameter AW = 4
)
(
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst_n,
  // option fetch
  input  wire          opt_rd_req,
  input  wire [15:0]   opt_rd_addr,
  output reg           opt_rd_valid,
  output reg  [7:0]    opt_rd_data,
  output reg           opt_dbl_fault,
  // verify read
  input  wire          op_rd,
  input  wire [AW-1:0] op_addr,
  output wire          arr_erased,
  // controls from the bench
  input  wire [3:0]    lat,
  input  wire [7:0]    nv_byte,
  input  wire          fault_en,
  input  wire          dirty_en,
  input  wire [AW-1:0] dirty_addr
);
  reg [3:0] cnt;
  reg       idle_tgl;
  // verify answer stands in the same cycle as op_rd
  assign arr_erased = op_rd ? !(dirty_en && op_addr == dirty_addr)
                            : idle_tgl;
  always @(posedge sys_clk)
  begin
    // idle answers toggle so stale values never pass as real
    opt_rd_valid  <= 1'b0;
    opt_rd_data   <= ~opt_rd_data;
    opt_dbl_fault <= ~opt_dbl_fault;
    idle_tgl      <= ~idle_tgl;
    if (!rst_n)
    begin
      cnt           <= 4'h0;
      opt_rd_data   <= 8'h00;
      opt_dbl_fault <= 1'b0;
      idle_tgl      <= 1'b0;
    end
    else if (!opt_rd_req || opt_rd_valid)
      cnt <= 4'h0;
    else if (cnt == lat)
    begin
      opt_rd_valid  <= 1'b1;
      opt_rd_data   <= (opt_rd_addr == 16'h7F0E) ? nv_byte : 8'h00;
      opt_dbl_fault <= fault_en;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule

/* File: testbench/fcs_seq_asserts.sv */
`timescale 1ns/100ps
`include "fcs_consts.vh"
// ==========
// port checks for the command sequencer
module fcs_seq_asserts
#(
  parameter AW        = 14,
  parameter ARRAY_CNT = 16384
)
(
  // clock and reset
  input wire          sys_clk,
  input wire          rst_n,
  // register port
  input wire [3:0]    reg_addr,
  input wire [7:0]    reg_wdata,
  input wire          reg_wr,
  input wire          reg_rd,
  input wire [7:0]    reg_rdata,
  // array write and protection
  input wire          arr_wr,
  input wire [AW-1:0] arr_waddr,
  input wire [15:0]   arr_wdata,
  input wire          prot_hit,
  input wire          prot_any,
  // array operation and fetch
  input wire          op_prog,
  input wire          op_erase,
  input wire          op_mass,
  input wire [AW-1:0] op_addr,
  input wire [15:0]   op_data,
  input wire          op_rd,
  input wire          opt_rd_req,
  input wire [15:0]   opt_rd_addr,
  input wire          cmd_done
);
  reg          div_seen;
  reg [6:0]    cmd_code;
  reg [AW-1:0] wa;
  reg [15:0]   wd;
  reg [3:0]    since_go;
  wire         any_op;
  assign any_op = op_prog | op_erase | op_mass | op_rd;
  // ==========
  // helper state
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_seen <= 1'b0;
      since_go <= 4'hF;
    end
    else
    begin
      if (reg_wr && reg_addr == `FCS_REG_DIV)
        div_seen <= 1'b1;
      if (reg_wr && reg_addr == `FCS_REG_STAT && reg_wdata[7])
        since_go <= 4'h0;
      else if (since_go != 4'hF)
        since_go <= since_go + 4'h1;
    end
    if (reg_wr && reg_addr == `FCS_REG_CMD)
      cmd_code <= reg_wdata[6:0];
    if (arr_wr)
    begin
      wa <= arr_waddr;
      wd <= arr_wdata;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  opt_addr_a:
    assert property (opt_rd_req |-> opt_rd_addr == `FCS_OPT_ADDR)
    else $error("option fetch address wrong");
  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  undiv_idle_a:
    assert property (!div_seen |-> !any_op)
    else $error("operation without a loaded divider");
  mass_prot_a:
    assert property ($rose(op_mass) |-> !$past(prot_any))
    else $error("mass erase under protection");
  prog_prot_a:
    assert property ($rose(op_prog) |-> !$past(prot_hit))
    else $error("program of a protected address");
  prog_data_a:
    assert property ($rose(op_prog) && cmd_code == `FCS_CMD_PROG
      |-> op_addr == wa && op_data == wd)
    else $error("program address or data wrong");
  prog_done_a:
    assert property ($fell(op_prog) |-> ##[1:8] cmd_done ##1 !cmd_done)
    else $error("completion pulse missing after program");
  launch_gap_a:
    assert property ($rose(op_prog) || $rose(op_erase) || $rose(op_mass)
      |-> since_go < 4'h8)
    else $error("operation started without a launch");
endmodule
bind fcs_sequencer fcs_seq_asserts #(.AW(AW), .ARRAY_CNT(ARRAY_CNT)) i_chk
  (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .arr_wr, .arr_waddr, .arr_wdata, .prot_hit, .prot_any, .op_prog,
   .op_erase, .op_mass, .op_addr, .op_data, .op_rd, .opt_rd_req,
   .opt_rd_addr, .cmd_done);

/* File: testbench/tb.sv */
`timescale 1ns/100ps
`include "fcs_consts.vh"
module tb;
  localparam CNT = 16;
  reg         sys_clk, rst_n, reg_wr, reg_rd, arr_wr, prot_hit, prot_any;
  reg  [3:0]  reg_addr, arr_waddr, lat, dirty_addr, pa;
  reg  [7:0]  reg_wdata, nv_byte;
  reg  [15:0] arr_wdata, pd;
  reg         fault_en, dirty_en, op_seen;
  wire [7:0]  reg_rdata, opt_rd_data;
  wire [3:0]  op_addr;
  wire [15:0] op_data, opt_rd_addr;
  wire        op_prog, op_erase, op_mass, op_rd, arr_erased, cmd_done;
  wire        opt_rd_req, opt_rd_valid, opt_dbl_fault;
  integer     miscompares, samples_checked, cycles, t, i;
  reg  [6:0]  codes [0:2];
  fcs_sequencer #(.AW(4), .ARRAY_CNT(CNT)) i_dut (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .arr_wr,
    .arr_waddr, .arr_wdata, .prot_hit, .prot_any, .op_prog, .op_erase,
    .op_mass, .op_addr, .op_data, .op_rd, .arr_erased, .opt_rd_req,
    .opt_rd_addr, .opt_rd_valid, .opt_rd_data, .opt_dbl_fault, .cmd_done);
  fcs_array_model #(.AW(4)) i_arr (.sys_clk, .rst_n, .opt_rd_req,
    .opt_rd_addr, .opt_rd_valid, .opt_rd_data, .opt_dbl_fault, .op_rd,
    .op_addr, .arr_erased, .lat, .nv_byte, .fault_en, .dirty_en,
    .dirty_addr);
  // ==========
  // clock, watchdog, operation monitor
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (op_prog | op_erase | op_mass)
      op_seen <= 1'b1;
    if (op_prog)
      pa <= op_addr;
    if (op_prog)
      pd <= op_data;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  // ==========
  // tasks
  task check(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  end
  endtask
  // one full sequence: array write, command, launch
  task cmd(input [3:0] a, input [15:0] d, input [6:0] c);
  begin
    @(posedge sys_clk);
    arr_waddr <= a;
    arr_wdata <= d;
    arr_wr    <= 1'b1;
    @(posedge sys_clk);
    arr_wr <= 1'b0;
    wr(`FCS_REG_CMD, {1'b0, c});
    wr(`FCS_REG_STAT, 8'h80);
  end
  endtask
  task wait_done;
  begin
    t = 0;
    while (cmd_done !== 1'b1 && t < 2000)
    begin
      @(posedge sys_clk);
      #1;
      t = t + 1;
    end
    check(cmd_done, 1'b1);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // ==========
  // tests
  initial
  begin
    {rst_n, reg_wr, reg_rd, arr_wr, prot_hit, prot_any} = 6'h00;
    {reg_addr, arr_waddr, reg_wdata, arr_wdata} = 32'h0;
    {lat, dirty_addr, fault_en, dirty_en, op_seen} = 11'h0;
    nv_byte = 8'h5A;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    codes[0] = `FCS_CMD_BURST;
    codes[1] = `FCS_CMD_SECERS;
    codes[2] = `FCS_CMD_MASERS;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(`FCS_REG_STAT, `FCS_STAT_RESET);
    rd(`FCS_REG_DIV, 8'h00);
    rd(`FCS_REG_OPT, 8'h5A);
    wr(`FCS_REG_OPT, 8'h00);
    rd(`FCS_REG_OPT, 8'h5A);
    $display("reset and option byte test done");
    cmd(4'h1, 16'h1234, `FCS_CMD_PROG);
    rd(`FCS_REG_STAT, 8'hD0);
    repeat (40) @(posedge sys_clk);
    check(op_seen, 1'b0);
    wr(`FCS_REG_STAT, 8'h10);
    // short divider keeps the timed operations brief
    wr(`FCS_REG_DIV, 8'h01);
    rd(`FCS_REG_DIV, 8'h81);
    $display("divider test done");
    cmd(4'h5, 16'hA5A5, `FCS_CMD_PROG);
    rd(`FCS_REG_STAT, 8'h00);
    wait_done;
    check({pa, pd}, 20'h5A5A5);
    rd(`FCS_REG_STAT, 8'hC0);
    prot_hit <= 1'b1;
    op_seen = 1'b0;
    cmd(4'h6, 16'h0F0F, `FCS_CMD_PROG);
    rd(`FCS_REG_STAT, 8'hE0);
    check(op_seen, 1'b0);
    prot_hit <= 1'b0;
    wr(`FCS_REG_STAT, 8'h20);
    cmd(4'h0, 16'h0000, 7'h33);
    rd(`FCS_REG_STAT, 8'hD0);
    wr(`FCS_REG_STAT, 8'h10);
    cmd(4'h0, 16'h0005, `FCS_CMD_MARGIN);
    rd(`FCS_REG_STAT, 8'hD0);
    wr(`FCS_REG_STAT, 8'h10);
    $display("program and refusal test done");
    cmd(4'h9, 16'h1234, `FCS_CMD_ERSVFY);
    wait_done;
    check(t >= CNT && t <= CNT + 16, 1'b1);
    rd(`FCS_REG_STAT, 8'hC4);
    dirty_addr <= 4'h3;
    dirty_en   <= 1'b1;
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(`FCS_REG_MODE, i[7:0]);
      cmd(4'h0, 16'h0000, `FCS_CMD_ERSVFY);
      wait_done;
      check(t < CNT, 1'b1);
      rd(`FCS_REG_STAT, i ? 8'hC2 : 8'hC0);
    end
    wr(`FCS_REG_STAT, 8'h10);
    rd(`FCS_REG_STAT, 8'hC2);
    wr(`FCS_REG_STAT, 8'h02);
    rd(`FCS_REG_STAT, 8'hC0);
    cmd(4'h0, 16'h0024, `FCS_CMD_MARGIN);
    wait_done;
    rd(`FCS_REG_STAT, 8'hC0);
    rd(`FCS_REG_MARGIN, 8'h24);
    wr(`FCS_REG_MODE, 8'h00);
    dirty_en <= 1'b0;
    $display("erase verify test done");
    for (i = 0; i < 3; i = i + 1)
    begin
      op_seen = 1'b0;
      cmd(4'h2, 16'h00FF, codes[i]);
      wait_done;
      check(op_seen, 1'b1);
      rd(`FCS_REG_STAT, 8'hC0);
    end
    prot_any <= 1'b1;
    op_seen = 1'b0;
    cmd(4'h0, 16'h0000, `FCS_CMD_MASERS);
    repeat (300) @(posedge sys_clk);
    check(op_seen, 1'b0);
    rd(`FCS_REG_STAT, 8'hE0);
    prot_any <= 1'b0;
    $display("command code test done");
    rst_n    <= 1'b0;
    fault_en <= 1'b1;
    lat      <= 4'h7;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(`FCS_REG_OPT, `FCS_OPT_FAULT);
    rd(`FCS_REG_DIV, 8'h00);
    $display("second reset test done");
    conclude;
  end
endmodule
